/* shared/bopid_pkg.sv */
// Constants, opcode classes and field layout for the byte-op instruction decoder
package bopid_pkg;

   // Field layout of a 16-bit instruction word
   localparam int WORD_W    = 16;
   localparam int FILE_MSB  = 7;
   localparam int DEST_BIT  = 9;
   localparam int ACC_BIT   = 8;
   localparam int BIT_MSB   = 11;
   localparam int BIT_LSB   = 9;
   localparam int LONG_MSB  = 11;
   localparam int BRA_MSB   = 10;
   localparam logic [3:0] SECOND_PREFIX = 4'hF;
   localparam logic [3:0] MOVE_PREFIX   = 4'hC;

   // Flag mask order {carry, digit carry, zero, overflow, negative}
   localparam logic [4:0] FLG_NONE = 5'h00;
   localparam logic [4:0] FLG_ALL  = 5'h1F;
   localparam logic [4:0] FLG_ZN   = 5'h05;
   localparam logic [4:0] FLG_CZN  = 5'h15;
   localparam logic [4:0] FLG_Z    = 5'h04;

   // Access-bank special addresses (arbitrary placement)
   localparam logic [7:0] TIMER0_ADDR   = 8'hD6;
   localparam logic [7:0] PORT_ADDR_LO  = 8'h80;
   localparam logic [7:0] PORT_ADDR_HI  = 8'h84;

   // Register port map
   localparam logic [1:0] REG_CTRL   = 2'h0;
   localparam logic [1:0] REG_STATUS = 2'h1;
   localparam logic [1:0] REG_LASTOP = 2'h2;
   localparam logic [7:0] CTRL_RESET = 8'h01;

   typedef enum logic [1:0] {
      ST_EXEC  = 2'h0,
      ST_WORD2 = 2'h1,
      ST_SKIP2 = 2'h2
   } bopid_state_e;

   typedef enum logic [5:0] {
      OP_NOP          = 6'h00, OP_ADD_W_TO_FILE     = 6'h01,
      OP_ADD_W_CARRY  = 6'h02, OP_AND_W_WITH_FILE   = 6'h03,
      OP_OR_W_FILE    = 6'h04, OP_XOR_W_WITH_FILE   = 6'h05,
      OP_COMPLEMENT   = 6'h06, OP_CLEAR_FILE        = 6'h07,
      OP_CMP_EQUAL    = 6'h08, OP_CMP_GREATER       = 6'h09,
      OP_CMP_LESS     = 6'h0A, OP_DECREMENT_FILE    = 6'h0B,
      OP_DEC_SKIP_Z   = 6'h0C, OP_DEC_SKIP_NZ       = 6'h0D,
      OP_INCREMENT    = 6'h0E, OP_INC_SKIP_Z        = 6'h0F,
      OP_INC_SKIP_NZ  = 6'h10, OP_MOVE_FILE         = 6'h11,
      OP_MOVE_F_TO_F  = 6'h12, OP_MOVE_W_TO_FILE    = 6'h13,
      OP_MULTIPLY     = 6'h14, OP_NEGATE_FILE       = 6'h15,
      OP_ROT_L_CARRY  = 6'h16, OP_ROT_L_PLAIN       = 6'h17,
      OP_ROT_R_CARRY  = 6'h18, OP_ROT_R_PLAIN       = 6'h19,
      OP_SET_FILE     = 6'h1A, OP_SUB_F_FROM_W_B    = 6'h1B,
      OP_SUB_W_FROM_F = 6'h1C, OP_SUB_W_FROM_F_B    = 6'h1D,
      OP_SWAP_NIBBLES = 6'h1E, OP_TEST_SKIP_ZERO    = 6'h1F,
      OP_BIT_MODIFY   = 6'h20, OP_BIT_TEST          = 6'h21,
      OP_LITERAL      = 6'h22, OP_ABSOLUTE_JUMP     = 6'h23,
      OP_CALL         = 6'h24, OP_RELATIVE_BRANCH   = 6'h25,
      OP_COND_BRANCH  = 6'h26, OP_REL_CALL          = 6'h27,
      OP_LOAD_POINTER = 6'h28, OP_OTHER             = 6'h29
   } bopid_op_e;

endpackage : bopid_pkg

/* core/bopid_decoder.sv */
// Instruction decoder for byte-oriented file operations and field formats
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module bopid_decoder (
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr_word,
   input  wire logic        dp_cond_true,
   input  wire logic [3:0]  bank_select_register,
   input  wire logic        prescaler_assigned,
   input  wire logic        tblwr_start,
   input  wire logic        tblwr_done,
   input  wire logic [1:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata_r,
   output logic             dec_valid_r,
   output logic             nop_r,
   output bopid_pkg::bopid_op_e op_r,
   output logic             dest_file_r,
   output logic             bank_use_bsr_r,
   output logic [3:0]       bank_r,
   output logic [11:0]      file_addr_r,
   output logic [11:0]      dst_addr_r,
   output logic [2:0]       bit_pos_r,
   output logic [7:0]       literal_r,
   output logic [19:0]      target_r,
   output logic [10:0]      branch_off_r,
   output logic [4:0]       flag_upd_r,
   output logic             cond_op_r,
   output logic             jump_r,
   output logic             use_pin_level_r,
   output logic             clr_prescaler_r,
   output logic             tblwr_busy_r
);

   bopid_pkg::bopid_state_e state_r;
   bopid_pkg::bopid_state_e state_nxt;
   logic [15:0]             first_r;
   logic [15:0]             w_r;
   logic [7:0]              ctrl_r;
   logic                    flush_hold_r;
   logic                    flush_req;
   logic                    flush_skip;
   bopid_pkg::bopid_op_e    op_nxt;
   logic                    is_nop_nxt;
   logic                    wr_file;

   // Opcode class of one word; the second word of a pair is never decoded here
   function automatic bopid_pkg::bopid_op_e decode_op(input logic [15:0] w);
      bopid_pkg::bopid_op_e o;
      o = bopid_pkg::OP_OTHER;
      case (w[15:10])
         6'h09: o = bopid_pkg::OP_ADD_W_TO_FILE;
         6'h08: o = bopid_pkg::OP_ADD_W_CARRY;
         6'h05: o = bopid_pkg::OP_AND_W_WITH_FILE;
         6'h07: o = bopid_pkg::OP_COMPLEMENT;
         6'h04: o = bopid_pkg::OP_OR_W_FILE;
         6'h06: o = bopid_pkg::OP_XOR_W_WITH_FILE;
         6'h01: o = bopid_pkg::OP_DECREMENT_FILE;
         6'h0B: o = bopid_pkg::OP_DEC_SKIP_Z;
         6'h13: o = bopid_pkg::OP_DEC_SKIP_NZ;
         6'h0A: o = bopid_pkg::OP_INCREMENT;
         6'h0F: o = bopid_pkg::OP_INC_SKIP_Z;
         6'h12: o = bopid_pkg::OP_INC_SKIP_NZ;
         6'h14: o = bopid_pkg::OP_MOVE_FILE;
         6'h0D: o = bopid_pkg::OP_ROT_L_CARRY;
         6'h11: o = bopid_pkg::OP_ROT_L_PLAIN;
         6'h0C: o = bopid_pkg::OP_ROT_R_CARRY;
         6'h10: o = bopid_pkg::OP_ROT_R_PLAIN;
         6'h15: o = bopid_pkg::OP_SUB_F_FROM_W_B;
         6'h17: o = bopid_pkg::OP_SUB_W_FROM_F;
         6'h16: o = bopid_pkg::OP_SUB_W_FROM_F_B;
         6'h0E: o = bopid_pkg::OP_SWAP_NIBBLES;
         default: o = bopid_pkg::OP_OTHER;
      endcase
      case (w[15:9])
         7'h30: o = bopid_pkg::OP_CMP_LESS;
         7'h31: o = bopid_pkg::OP_CMP_EQUAL;
         7'h32: o = bopid_pkg::OP_CMP_GREATER;
         7'h33: o = bopid_pkg::OP_TEST_SKIP_ZERO;
         7'h34: o = bopid_pkg::OP_SET_FILE;
         7'h35: o = bopid_pkg::OP_CLEAR_FILE;
         7'h36: o = bopid_pkg::OP_NEGATE_FILE;
         7'h37: o = bopid_pkg::OP_MOVE_W_TO_FILE;
         7'h01: o = bopid_pkg::OP_MULTIPLY;
         7'h76: o = bopid_pkg::OP_CALL;
         default: ;
      endcase
      case (w[15:12])
         4'hC: o = bopid_pkg::OP_MOVE_F_TO_F;
         4'h7, 4'h8, 4'h9: o = bopid_pkg::OP_BIT_MODIFY;
         4'hA, 4'hB: o = bopid_pkg::OP_BIT_TEST;
         4'hD: o = w[11] ? bopid_pkg::OP_REL_CALL
                         : bopid_pkg::OP_RELATIVE_BRANCH;
         4'hF: o = bopid_pkg::OP_NOP;
         default: ;
      endcase
      if (w[15:11] == 5'h1C)
         o = bopid_pkg::OP_COND_BRANCH;
      if (w[15:8] == 8'hEF)
         o = bopid_pkg::OP_ABSOLUTE_JUMP;
      if (w[15:8] == 8'hEE)
         o = bopid_pkg::OP_LOAD_POINTER;
      if (w[15:11] == 5'h01 || w[15:8] == 8'h01)
         o = bopid_pkg::OP_LITERAL;
      if (w == 16'h0000)
         o = bopid_pkg::OP_NOP;
      return o;
   endfunction

   // Flags touched by each class
   function automatic logic [4:0] flags_of(input bopid_pkg::bopid_op_e o);
      case (o)
         bopid_pkg::OP_ADD_W_TO_FILE, bopid_pkg::OP_ADD_W_CARRY,
         bopid_pkg::OP_INCREMENT, bopid_pkg::OP_DECREMENT_FILE,
         bopid_pkg::OP_SUB_W_FROM_F, bopid_pkg::OP_SUB_W_FROM_F_B,
         bopid_pkg::OP_SUB_F_FROM_W_B,
         bopid_pkg::OP_NEGATE_FILE: return bopid_pkg::FLG_ALL;
         bopid_pkg::OP_AND_W_WITH_FILE, bopid_pkg::OP_OR_W_FILE,
         bopid_pkg::OP_XOR_W_WITH_FILE, bopid_pkg::OP_COMPLEMENT,
         bopid_pkg::OP_MOVE_FILE, bopid_pkg::OP_ROT_L_PLAIN,
         bopid_pkg::OP_ROT_R_PLAIN: return bopid_pkg::FLG_ZN;
         bopid_pkg::OP_ROT_L_CARRY,
         bopid_pkg::OP_ROT_R_CARRY: return bopid_pkg::FLG_CZN;
         bopid_pkg::OP_CLEAR_FILE: return bopid_pkg::FLG_Z;
         // everything else leaves the flag set alone
         default: return bopid_pkg::FLG_NONE;
      endcase
   endfunction

   // Classes whose result is conditional on the datapath
   function automatic logic is_cond(input bopid_pkg::bopid_op_e o);
      case (o)
         bopid_pkg::OP_CMP_EQUAL, bopid_pkg::OP_CMP_GREATER,
         bopid_pkg::OP_CMP_LESS, bopid_pkg::OP_TEST_SKIP_ZERO,
         bopid_pkg::OP_DEC_SKIP_Z, bopid_pkg::OP_DEC_SKIP_NZ,
         bopid_pkg::OP_INC_SKIP_Z, bopid_pkg::OP_INC_SKIP_NZ,
         bopid_pkg::OP_BIT_TEST, bopid_pkg::OP_COND_BRANCH: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // Classes carrying a destination bit
   function automatic logic has_dest(input bopid_pkg::bopid_op_e o);
      return (o >= bopid_pkg::OP_ADD_W_TO_FILE &&
              o <= bopid_pkg::OP_SWAP_NIBBLES &&
              o != bopid_pkg::OP_CLEAR_FILE && o != bopid_pkg::OP_CMP_EQUAL &&
              o != bopid_pkg::OP_CMP_GREATER && o != bopid_pkg::OP_CMP_LESS &&
              o != bopid_pkg::OP_MOVE_F_TO_F &&
              o != bopid_pkg::OP_MOVE_W_TO_FILE &&
              o != bopid_pkg::OP_MULTIPLY && o != bopid_pkg::OP_NEGATE_FILE &&
              o != bopid_pkg::OP_SET_FILE);
   endfunction

   // First word of a two-word pair
   function automatic logic is_pair(input logic [15:0] w);
      return (w[15:12] == bopid_pkg::MOVE_PREFIX) || (w[15:9] == 7'h76) ||
             (w[15:8] == 8'hEF) || (w[15:8] == 8'hEE);
   endfunction

   // Flush the word in flight after a jump or a true condition
   // extra no-op cycle
   assign flush_req  = flush_hold_r |
                       (dec_valid_r & ((cond_op_r & dp_cond_true) | jump_r));
   assign flush_skip = flush_req & (state_r == bopid_pkg::ST_EXEC);

   // Class of the word presented; disabled decode turns everything to no-op but the second word of a pair begun while enabled
   always_comb begin
      op_nxt     = decode_op(instr_word);
      is_nop_nxt = flush_req | ~ctrl_r[0] | (state_r == bopid_pkg::ST_SKIP2);
      if (is_nop_nxt)
         op_nxt = bopid_pkg::OP_NOP;
      if (state_r == bopid_pkg::ST_EXEC &&
          instr_word[15:12] == bopid_pkg::SECOND_PREFIX)
         op_nxt = bopid_pkg::OP_NOP;
      if (state_r == bopid_pkg::ST_WORD2)
         op_nxt = decode_op(first_r);
   end

   // Whether the result lands in a file register
   // destination select
   assign wr_file = has_dest(op_nxt) ? instr_word[bopid_pkg::DEST_BIT] :
                    (op_nxt == bopid_pkg::OP_CLEAR_FILE ||
                     op_nxt == bopid_pkg::OP_SET_FILE ||
                     op_nxt == bopid_pkg::OP_NEGATE_FILE ||
                     op_nxt == bopid_pkg::OP_MOVE_W_TO_FILE ||
                     op_nxt == bopid_pkg::OP_BIT_MODIFY);

   // Sequencing between single words, pairs and skipped pairs
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         bopid_pkg::ST_EXEC: begin
            // skipped pair costs one more cycle
            if (instr_valid && flush_skip && is_pair(instr_word))
               state_nxt = bopid_pkg::ST_SKIP2;
            else if (instr_valid && !is_nop_nxt && is_pair(instr_word))
               state_nxt = bopid_pkg::ST_WORD2;
         end
         bopid_pkg::ST_WORD2,
         bopid_pkg::ST_SKIP2: begin
            if (instr_valid)
               state_nxt = bopid_pkg::ST_EXEC;
         end
         default: state_nxt = bopid_pkg::ST_EXEC;
      endcase
   end

   // State and pair latch
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state_r      <= bopid_pkg::ST_EXEC;
         first_r      <= 16'h0000;
         flush_hold_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (instr_valid && state_r == bopid_pkg::ST_EXEC)
            first_r <= instr_word;
         // A flush waits for the next real word if fetch stalls
         flush_hold_r <= flush_req & ~instr_valid;
      end
   end

   // Decoded fields, held until the next word is taken
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         dec_valid_r     <= 1'b0;
         nop_r           <= 1'b1;
         op_r            <= bopid_pkg::OP_NOP;
         w_r             <= 16'h0000;
         dest_file_r     <= 1'b0;
         bank_use_bsr_r  <= 1'b0;
         bank_r          <= 4'h0;
         file_addr_r     <= 12'h000;
         dst_addr_r      <= 12'h000;
         bit_pos_r       <= 3'h0;
         literal_r       <= 8'h00;
         target_r        <= 20'h00000;
         branch_off_r    <= 11'h000;
         flag_upd_r      <= bopid_pkg::FLG_NONE;
         cond_op_r       <= 1'b0;
         jump_r          <= 1'b0;
         use_pin_level_r <= 1'b0;
         clr_prescaler_r <= 1'b0;
      end else begin
         // The pair's first word only latches; output waits for word two
         dec_valid_r <= instr_valid & (state_nxt != bopid_pkg::ST_WORD2);
         if (instr_valid) begin
            op_r        <= op_nxt;
            nop_r       <= (op_nxt == bopid_pkg::OP_NOP);
            w_r         <= instr_word;
            flag_upd_r  <= flags_of(op_nxt);
            cond_op_r   <= is_cond(op_nxt);
            jump_r      <= (op_nxt == bopid_pkg::OP_ABSOLUTE_JUMP) ||
                           (op_nxt == bopid_pkg::OP_CALL) ||
                           (op_nxt == bopid_pkg::OP_RELATIVE_BRANCH) ||
                           (op_nxt == bopid_pkg::OP_REL_CALL);
            dest_file_r <= wr_file;
            // access bank or bank select register
            bank_use_bsr_r <= instr_word[bopid_pkg::ACC_BIT];
            bank_r <= instr_word[bopid_pkg::ACC_BIT] ? bank_select_register
                                                     : 4'h0;
            file_addr_r <= {4'h0, instr_word[bopid_pkg::FILE_MSB:0]};
            bit_pos_r <= instr_word[bopid_pkg::BIT_MSB:bopid_pkg::BIT_LSB];
            literal_r <= instr_word[bopid_pkg::FILE_MSB:0];
            if (op_nxt == bopid_pkg::OP_COND_BRANCH)
               branch_off_r <= {{3{instr_word[bopid_pkg::FILE_MSB]}},
                                instr_word[bopid_pkg::FILE_MSB:0]};
            else
               branch_off_r <= instr_word[bopid_pkg::BRA_MSB:0];
            use_pin_level_r <= wr_file & ~instr_word[bopid_pkg::ACC_BIT] &
               (instr_word[bopid_pkg::FILE_MSB:0] >= bopid_pkg::PORT_ADDR_LO) &
               (instr_word[bopid_pkg::FILE_MSB:0] <= bopid_pkg::PORT_ADDR_HI);
            clr_prescaler_r <= wr_file & prescaler_assigned &
               ~instr_word[bopid_pkg::ACC_BIT] &
               (instr_word[bopid_pkg::FILE_MSB:0] == bopid_pkg::TIMER0_ADDR);
            if (state_r == bopid_pkg::ST_WORD2) begin
               dest_file_r     <= 1'b0;
               use_pin_level_r <= 1'b0;
               clr_prescaler_r <= 1'b0;
               bank_use_bsr_r  <= 1'b0;
               bank_r          <= 4'h0;
               file_addr_r <= first_r[bopid_pkg::LONG_MSB:0];
               dst_addr_r  <= instr_word[bopid_pkg::LONG_MSB:0];
               target_r <= {instr_word[bopid_pkg::LONG_MSB:0],
                            first_r[bopid_pkg::FILE_MSB:0]};
            end
         end
      end
   end

   // Table write holds until its own completion; start wins over done
   // write runs to completion
   always_ff @(posedge clk_sys) begin
      if (!resetn)
         tblwr_busy_r <= 1'b0;
      else if (tblwr_start)
         tblwr_busy_r <= 1'b1;
      else if (tblwr_done)
         tblwr_busy_r <= 1'b0;
   end

   // Control register: bit 0 enables decoding
   always_ff @(posedge clk_sys) begin
      if (!resetn)
         ctrl_r <= bopid_pkg::CTRL_RESET;
      else if (reg_wr && reg_addr == bopid_pkg::REG_CTRL)
         ctrl_r <= reg_wdata;
   end

   // Read data stands one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_sys) begin
      if (!resetn)
         reg_rdata_r <= 8'h00;
      else if (!reg_rd)
         reg_rdata_r <= 8'h00;
      else begin
         case (reg_addr)
            bopid_pkg::REG_CTRL:   reg_rdata_r <= ctrl_r;
            bopid_pkg::REG_STATUS: reg_rdata_r <= {5'h00, tblwr_busy_r,
                                                   state_r};
            bopid_pkg::REG_LASTOP: reg_rdata_r <= {2'h0, op_r};
            default:               reg_rdata_r <= 8'h00;
         endcase
      end
   end

   // Checks on the decoded outputs
   sequence s_pair_first;
      instr_valid && state_r == bopid_pkg::ST_EXEC && !flush_req &&
      ctrl_r[0] && is_pair(instr_word);
   endsequence
   sequence s_skip_pair;
      instr_valid && flush_skip && is_pair(instr_word);
   endsequence

   a_dest_select: assert property (@(posedge clk_sys) disable iff (!resetn)
      (dec_valid_r && has_dest(op_r)) |-> dest_file_r == w_r[9])
      else $error("destination select mismatch");
   a_bank_force: assert property (@(posedge clk_sys) disable iff (!resetn)
      (dec_valid_r && op_r == bopid_pkg::OP_MOVE_FILE && !w_r[8])
      |-> (!bank_use_bsr_r && bank_r == 4'h0))
      else $error("access bank not forced");
   a_file_field: assert property (@(posedge clk_sys) disable iff (!resetn)
      (instr_valid && state_r == bopid_pkg::ST_EXEC && !is_pair(instr_word))
      |=> file_addr_r == {4'h0, $past(instr_word[7:0])})
      else $error("file address field wrong");
   a_bit_field: assert property (@(posedge clk_sys) disable iff (!resetn)
      (dec_valid_r && op_r == bopid_pkg::OP_BIT_MODIFY)
      |-> bit_pos_r == w_r[11:9])
      else $error("bit position field wrong");
   a_target_build: assert property (@(posedge clk_sys) disable iff (!resetn)
      (s_pair_first ##1 (instr_valid && instr_word[15:12] == 4'hF))
      |=> (dec_valid_r && target_r[7:0] == first_r[7:0] &&
           target_r[19:8] == w_r[11:0]))
      else $error("call target not assembled");
   a_move_flags: assert property (@(posedge clk_sys) disable iff (!resetn)
      (dec_valid_r && op_r == bopid_pkg::OP_MOVE_F_TO_F)
      |-> (flag_upd_r == bopid_pkg::FLG_NONE &&
           dst_addr_r == w_r[11:0]))
      else $error("file move decode wrong");
   // With fetch stalled while the jump is shown, the next word fetched is the one that gets flushed
   a_jump_flush: assert property (@(posedge clk_sys) disable iff (!resetn)
      (dec_valid_r && jump_r && !instr_valid ##1 instr_valid)
      |=> (dec_valid_r && nop_r))
      else $error("word after jump not flushed");
   a_jump_now: assert property (@(posedge clk_sys) disable iff (!resetn)
      (dec_valid_r && jump_r && instr_valid) |=> (dec_valid_r && nop_r))
      else $error("word beside jump not flushed");
   a_lone_second: assert property (@(posedge clk_sys) disable iff (!resetn)
      (instr_valid && state_r == bopid_pkg::ST_EXEC &&
       instr_word[15:12] == 4'hF) |=> nop_r)
      else $error("lone second word executed");
   a_tbl_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
      (tblwr_busy_r && !tblwr_done) |=> tblwr_busy_r)
      else $error("table write dropped early");
   a_skip_pair: assert property (@(posedge clk_sys) disable iff (!resetn)
      s_skip_pair ##1 instr_valid |=> (nop_r[*1] ##0
                                       state_r == bopid_pkg::ST_EXEC))
      else $error("skipped pair not flushed");
   a_logic_flags: assert property (@(posedge clk_sys) disable iff (!resetn)
      (dec_valid_r && op_r == bopid_pkg::OP_XOR_W_WITH_FILE)
      |-> flag_upd_r == bopid_pkg::FLG_ZN)
      else $error("logical flag mask wrong");

endmodule // bopid_decoder
`default_nettype wire

/* verif/bopid_dp_model.sv */
// Datapath stand-in that answers skip and branch conditions
`timescale 1ns/10ps
`default_nettype none
module bopid_dp_model (
   input  wire logic cond_op_r,
   input  wire logic want_true,
   output logic      dp_cond_true
);
   // Only a conditional op may report a true test
   always_comb dp_cond_true = cond_op_r & want_true;
endmodule // bopid_dp_model
`default_nettype wire

/* verif/byte_op_instruction_decoder_test.sv */
// Self-checking bench for the byte-op instruction decoder
`timescale 1ns/10ps
`default_nettype none
module byte_op_instruction_decoder_test;
   logic clk_sys, resetn, instr_valid, dp_cond_true, prescaler_assigned;
   logic tblwr_start, tblwr_done, reg_wr, reg_rd, want;
   logic dec_valid_r, nop_r, dest_file_r, bank_use_bsr_r, cond_op_r, jump_r;
   logic use_pin_level_r, clr_prescaler_r, tblwr_busy_r;
   logic [15:0] instr_word;
   logic [3:0]  bank_select_register, bank_r;
   logic [1:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata_r, literal_r, rv;
   logic [4:0]  flag_upd_r;
   logic [2:0]  bit_pos_r;
   logic [11:0] file_addr_r, dst_addr_r;
   logic [19:0] target_r;
   logic [10:0] branch_off_r;
   bopid_pkg::bopid_op_e op_r;
   int n_fail, compares;
   // Byte ops as {upper byte, op class, flag mask}
   logic [23:0] tbl [30] = '{24'h26011F, 24'h21021F, 24'h150305, 24'h120405,
      24'h1B0505, 24'h1C0605, 24'h6A0704, 24'h620800, 24'h650900, 24'h600A00,
      24'h070B1F, 24'h2E0C00, 24'h4D0D00, 24'h2A0E1F, 24'h3F0F00, 24'h481000,
      24'h521105, 24'h6E1300, 24'h031400, 24'h6D151F, 24'h361615, 24'h451705,
      24'h311815, 24'h421905, 24'h681A00, 24'h571B1F, 24'h5C1C1F, 24'h5A1D1F,
      24'h3B1E00, 24'h661F00};
   bopid_decoder bopid_decoder_inst (.clk_sys, .resetn, .instr_valid,
      .instr_word, .dp_cond_true, .bank_select_register, .prescaler_assigned,
      .tblwr_start, .tblwr_done, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata_r, .dec_valid_r, .nop_r, .op_r, .dest_file_r, .bank_use_bsr_r,
      .bank_r, .file_addr_r, .dst_addr_r, .bit_pos_r, .literal_r, .target_r,
      .branch_off_r, .flag_upd_r, .cond_op_r, .jump_r, .use_pin_level_r,
      .clr_prescaler_r, .tblwr_busy_r);
   bopid_dp_model bopid_dp_model_inst (.cond_op_r, .want_true(want),
      .dp_cond_true);
   task automatic chk(string n, logic [31:0] e, logic [31:0] s);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   // Words change just after an edge; the last one is checked after stop
   task automatic put(logic [15:0] w);
      @(posedge clk_sys);
      instr_valid <= 1'h1;
      instr_word <= w;
   endtask
   task automatic stop;
      @(posedge clk_sys);
      instr_valid <= 1'h0;
      #1;
   endtask
   task automatic one(logic [15:0] w);
      put(w);
      stop;
   endtask
   // Register port: one-cycle strobes, read data in the following cycle
   task automatic rd(logic [1:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      #1;
      rv = reg_rdata_r;
   endtask
   // Register write: one strobe cycle, the slave never waits
   task automatic wr(logic [1:0] a, logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
   endtask
   task automatic wrap_up;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Free-running 40 MHz clock
   initial begin
      clk_sys = 1'h0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Watchdog well beyond the roughly 120 cycles the tests need
   initial begin
      #50us;
      n_fail++;
      wrap_up;
   end
   // Main sequence
   initial begin
      {resetn, instr_valid, prescaler_assigned, tblwr_start, tblwr_done} = '0;
      {reg_wr, reg_rd, want, reg_addr, reg_wdata, instr_word} = '0;
      bank_select_register = 4'h9;
      repeat (4) @(posedge clk_sys);
      resetn <= 1'h1;
      rd(2'h0);
      chk("ctrl", 8'h01, rv);
      rd(2'h3);
      chk("unmapped", 8'h00, rv);
      foreach (tbl[i]) begin
         one({tbl[i][23:16], 8'h5A});
         chk("op", tbl[i][13:8], op_r);
         chk("flags", tbl[i][4:0], flag_upd_r);
         chk("addr", 12'h05A, file_addr_r);
         chk("bank", {tbl[i][16], tbl[i][16] ? 4'h9 : 4'h0},
            {bank_use_bsr_r, bank_r});
         chk("flgs", tbl[i][4:0], flag_upd_r);
      end
      one(16'h2401);
      chk("dest0", 1'h0, dest_file_r);
      one(16'h9B33);
      chk("bit", {3'h5, 12'h033}, {bit_pos_r, file_addr_r});
      one(16'h0E7F);
      chk("lit", 8'h7F, literal_r);
      put(16'hC123);
      put(16'hF456);
      stop;
      chk("move", {1'h0, 12'h123, 12'h456}, {|flag_upd_r, file_addr_r,
         dst_addr_r});
      one(16'hF123);
      chk("lone", 2'h3, {dec_valid_r, nop_r});
      put(16'hEF12);
      put(16'hF345);
      stop;
      chk("jump", {1'h1, 20'h34512}, {jump_r, target_r});
      one(16'h2601);
      chk("flush", 2'h3, {dec_valid_r, nop_r});
      // Back to back: the word beside the branch is flushed
      put(16'hD7FF);
      put(16'h2601);
      #1;
      chk("bra", 11'h7FF, branch_off_r);
      stop;
      chk("flush2", 2'h3, {dec_valid_r, nop_r});
      one(16'hE080);
      chk("bcond", 11'h780, branch_off_r);
      one(16'h6201);
      chk("skip", 2'h1, {nop_r, cond_op_r});
      // Condition true only while the compare is shown
      want <= 1'h1;
      put(16'hEF12);
      put(16'hF345);
      #1;
      chk("skip1", 2'h3, {dec_valid_r, nop_r});
      stop;
      chk("skip2", 2'h3, {dec_valid_r, nop_r});
      want <= 1'h0;
      prescaler_assigned <= 1'h1;
      one(16'h5280);
      chk("pins", 1'h1, use_pin_level_r);
      one(16'h2AD6);
      chk("psc", 1'h1, clr_prescaler_r);
      one(16'h28D6);
      chk("psc_w", 1'h0, clr_prescaler_r);
      rd(2'h2);
      chk("lastop", 8'h0E, rv);
      // Decode disabled turns every word outside a pair already begun into a no-op
      wr(2'h0, 8'h00);
      one(16'h2601);
      chk("off", 2'h3, {dec_valid_r, nop_r});
      wr(2'h0, 8'h01);
      rd(2'h0);
      chk("ctrl_on", 8'h01, rv);
      @(posedge clk_sys);
      tblwr_start <= 1'h1;
      @(posedge clk_sys);
      tblwr_start <= 1'h0;
      rd(2'h1);
      chk("busy", 1'h1, rv[2]);
      @(posedge clk_sys);
      tblwr_done <= 1'h1;
      @(posedge clk_sys);
      tblwr_done <= 1'h0;
      @(posedge clk_sys);
      #1;
      chk("idle", 1'h0, tblwr_busy_r);
      wrap_up;
   end
endmodule // byte_op_instruction_decoder_test
`default_nettype wire
